// ### common/tcci_pkg.sv
/*
  Shared constants for the terminal control code interpreter: control
  codes, composite status layout, register map, cursor limits and states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tcci_pkg;
  // Control codes
  localparam logic [7:0] CODE_ERASE_PAGE = 8'h0c;
  localparam logic [7:0] CODE_CR         = 8'h0d;
  localparam logic [7:0] CODE_HI_ON      = 8'h0e;
  localparam logic [7:0] CODE_BLINK_OFF  = 8'h0f;
  localparam logic [7:0] CODE_COLOR_LO   = 8'h10;
  localparam logic [7:0] CODE_COLOR_HI   = 8'h17;
  localparam logic [7:0] CODE_TRANSMIT   = 8'h18;
  localparam logic [7:0] CODE_RIGHT      = 8'h19;
  localparam logic [7:0] CODE_LEFT       = 8'h1a;
  localparam logic [7:0] CODE_ESCAPE     = 8'h1b;
  localparam logic [7:0] CODE_UP         = 8'h1c;
  localparam logic [7:0] CODE_FLAG_OFF   = 8'h1d;
  localparam logic [7:0] CODE_FLAG_ON    = 8'h1e;
  localparam logic [7:0] CODE_BLINK_ON   = 8'h1f;
  localparam logic [7:0] CODE_PRINT_LO   = 8'h20;
  localparam logic [7:0] CODE_SPECIAL_LO = 8'h60;
  localparam logic [7:0] CODE_SPECIAL_HI = 8'h7f;
  localparam logic [7:0] SPECIAL_OFFSET  = 8'h60;
  localparam logic [7:0] SPACE_CHAR      = 8'h20;
  localparam logic [7:0] CR_PLAIN        = 8'h0d;
  localparam logic [7:0] CR_HIGH         = 8'h8d;
  localparam logic [7:0] END_CHAR        = 8'hff;
  localparam logic [7:0] END_STATUS      = 8'h00;

  // Escape functions
  localparam logic [4:0] ESC_VISIBLE     = 5'h00;
  localparam logic [4:0] ESC_FULL_DUPLEX = 5'h06;
  localparam logic [4:0] ESC_HALF_DUPLEX = 5'h08;
  localparam logic [4:0] ESC_LOCAL       = 5'h0c;
  localparam logic [31:0] ESC_UNUSED_MASK = 32'h0800_6290;

  // Communication modes
  localparam logic [1:0] COMM_LOCAL = 2'h0;
  localparam logic [1:0] COMM_HALF  = 2'h1;
  localparam logic [1:0] COMM_FULL  = 2'h2;

  // Composite status fields
  localparam int FG_LSB    = 0;
  localparam int BG_LSB    = 3;
  localparam int BLINK_BIT = 6;
  localparam int PLOT_BIT  = 7;
  localparam logic [7:0] STATUS_RESET = 8'h07;

  // Screen geometry
  localparam logic [6:0] LAST_COL       = 7'h4f;
  localparam logic [5:0] LAST_LINE_25   = 6'h18;
  localparam logic [5:0] LAST_LINE_48   = 6'h2f;
  localparam int         MEM_DEPTH      = 3840;
  localparam int         ADDR_W         = 12;
  localparam logic [11:0] LAST_ADDR_25  = 12'h7cf;
  localparam logic [11:0] LAST_ADDR_48  = 12'heff;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CURSOR   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_KBD_MODE = 8'h0c;
  localparam logic [7:0] REG_SER_MODE = 8'h10;
  localparam int CTRL_CR_HIGH_BIT = 0;
  localparam int CTRL_TALL_BIT    = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int CURSOR_Y_LSB   = 8;
  localparam int STAT_REV_BIT   = 8;
  localparam int STAT_HI_BIT    = 9;
  localparam int STAT_BUSY_BIT  = 10;
  localparam int MODE_COMM_LSB  = 8;
  localparam int MODE_ESC_BIT   = 12;

  typedef enum logic [5:0] {
    TCCI_IDLE    = 6'b000001,
    TCCI_ERASE   = 6'b000010,
    TCCI_TX_READ = 6'b000100,
    TCCI_TX_CHAR = 6'b001000,
    TCCI_TX_STAT = 6'b010000,
    TCCI_TX_CR   = 6'b100000
  } tcci_state_t;
endpackage

// ### verilog/tcci_refresh_mem.sv
/*
  Refresh memory: one word per screen position, character in the low byte
  and its status in the high byte. Single port, registered read data.
  Assumes one clock and a clock enable; the array and read register have no reset.
*/
`timescale 1ns/1ps
module tcci_refresh_mem (
  input  wire logic                       clk,
  input  wire logic                       ce,
  input  wire logic                       we,
  input  wire logic                       re,
  input  wire logic [tcci_pkg::ADDR_W-1:0] addr,
  input  wire logic [15:0]                wdata,
  output logic      [15:0]                rdata_ff
);
  logic [15:0] mem [tcci_pkg::MEM_DEPTH];

  // Read data holds until the next read so the sender can use it late
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && re) begin
      rdata_ff <= mem[addr];
    end
  end
endmodule

// ### verilog/tcci_port_mode.sv
/*
  Per-input-port mode flags: escape prefix pending, selected escape mode
  and communication mode. One instance per input port.
  Assumes bytes are offered with a one-cycle take pulse.
*/
`timescale 1ns/1ps
module tcci_port_mode (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       take,
  input  wire logic [7:0] data,
  output logic            esc_ff,
  output logic [4:0]      mode_ff,
  output logic [1:0]      comm_ff
);
  logic [4:0] func;

  assign func = data[4:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      esc_ff <= 1'b0;
    end else if (ce && take) begin
      esc_ff <= !esc_ff && (data == tcci_pkg::CODE_ESCAPE);
    end
  end

  // Unused slots leave mode and comm as they were
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= tcci_pkg::ESC_VISIBLE;
      comm_ff <= tcci_pkg::COMM_LOCAL;
    end else if (ce && take && esc_ff) begin
      if (func == tcci_pkg::ESC_FULL_DUPLEX) begin
        comm_ff <= tcci_pkg::COMM_FULL;
      end else if (func == tcci_pkg::ESC_HALF_DUPLEX) begin
        comm_ff <= tcci_pkg::COMM_HALF;
      end else if (func == tcci_pkg::ESC_LOCAL) begin
        comm_ff <= tcci_pkg::COMM_LOCAL;
      end else if (!tcci_pkg::ESC_UNUSED_MASK[func]) begin
        mode_ff <= func;
      end
    end
  end
endmodule

// ### verilog/tcci_top.sv
/*
  Terminal control code interpreter. Takes bytes from a keyboard port and
  a serial port, keeps cursor, composite status and reverse-field flag,
  writes the refresh memory, erases the page and transmits screen data.
  Assumes one 100 MHz clock, synchronous inputs, a consumer on TX that
  may stall, and software on a plain strobe register port.
*/
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module tcci_top (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic        KBD_VALID,
  input  wire logic [7:0]  KBD_DATA,
  output logic             KBD_READY,
  input  wire logic        SER_VALID,
  input  wire logic [7:0]  SER_DATA,
  output logic             SER_READY,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  input  wire logic        TX_READY,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA
);
  tcci_pkg::tcci_state_t state_ff;
  tcci_pkg::tcci_state_t nxt_state;

  logic [6:0]  cur_x_ff;
  logic [5:0]  cur_y_ff;
  logic [6:0]  blind_x_ff;
  logic [5:0]  blind_y_ff;
  logic [7:0]  status_ff;
  logic        rev_ff;
  logic        hi_ff;
  logic [1:0]  ctrl_ff;
  logic [11:0] ptr_ff;
  logic [7:0]  tx_data_ff;
  logic [31:0] rdata_ff;

  logic        kbd_take;
  logic        ser_take;
  logic        take;
  logic [7:0]  code;
  logic        esc_now;
  logic        kbd_drop;
  logic        kbd_esc;
  logic        ser_esc;
  logic [4:0]  kbd_mode;
  logic [4:0]  ser_mode;
  logic [1:0]  kbd_comm;
  logic [1:0]  ser_comm;
  logic [4:0]  port_mode;
  logic        ctl;
  logic        print;
  logic [5:0]  last_line;
  logic [11:0] last_addr;
  logic [11:0] cur_addr;
  logic [7:0]  stored_char;
  logic        mem_we;
  logic        mem_re;
  logic [11:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic        tx_fire;
  logic        word_end;

  // Keyboard wins over serial when both offer a byte
  assign KBD_READY = (state_ff == tcci_pkg::TCCI_IDLE);
  assign SER_READY = (state_ff == tcci_pkg::TCCI_IDLE) && !KBD_VALID;
  assign kbd_take  = CE && KBD_VALID && KBD_READY;
  assign ser_take  = CE && SER_VALID && SER_READY;
  assign take      = kbd_take || ser_take;
  assign code      = kbd_take ? KBD_DATA : SER_DATA;

  tcci_port_mode u_kbd_mode (
    .clk     (CLK),
    .rstn    (RSTN),
    .ce      (CE),
    .take    (kbd_take),
    .data    (KBD_DATA),
    .esc_ff  (kbd_esc),
    .mode_ff (kbd_mode),
    .comm_ff (kbd_comm)
  );

  tcci_port_mode u_ser_mode (
    .clk     (CLK),
    .rstn    (RSTN),
    .ce      (CE),
    .take    (ser_take),
    .data    (SER_DATA),
    .esc_ff  (ser_esc),
    .mode_ff (ser_mode),
    .comm_ff (ser_comm)
  );

  // Full duplex keyboard bytes are consumed but not interpreted here
  assign kbd_drop  = kbd_take && (kbd_comm == tcci_pkg::COMM_FULL);
  assign esc_now   = kbd_take ? kbd_esc : ser_esc;
  assign port_mode = kbd_take ? kbd_mode : ser_mode;
  // Escape prefix and its function byte are handled by the port module
  assign ctl = take && !kbd_drop && !esc_now &&
               (code != tcci_pkg::CODE_ESCAPE);
  assign print = ctl && (code >= tcci_pkg::CODE_PRINT_LO) &&
                 (port_mode == tcci_pkg::ESC_VISIBLE);

  assign last_line = ctrl_ff[tcci_pkg::CTRL_TALL_BIT] ?
                     tcci_pkg::LAST_LINE_48 : tcci_pkg::LAST_LINE_25;
  assign last_addr = ctrl_ff[tcci_pkg::CTRL_TALL_BIT] ?
                     tcci_pkg::LAST_ADDR_48 : tcci_pkg::LAST_ADDR_25;
  assign cur_addr  = {cur_y_ff, 6'h00} + {2'h0, cur_y_ff, 4'h0} +
                     {5'h00, cur_x_ff};

  always_comb begin
    stored_char = code;
    if (rev_ff && (code >= tcci_pkg::CODE_SPECIAL_LO) &&
        (code <= tcci_pkg::CODE_SPECIAL_HI)) begin
      stored_char = code - tcci_pkg::SPECIAL_OFFSET;
    end
    stored_char[7] = hi_ff;
  end

  // Memory port: erase sweep, character store, transmit read
  always_comb begin
    mem_we    = 1'b0;
    mem_re    = 1'b0;
    mem_addr  = cur_addr;
    mem_wdata = {status_ff, stored_char};
    if (state_ff == tcci_pkg::TCCI_ERASE) begin
      mem_we    = 1'b1;
      mem_addr  = ptr_ff;
      mem_wdata = {status_ff, tcci_pkg::SPACE_CHAR};
    end else if (state_ff == tcci_pkg::TCCI_TX_READ) begin
      mem_re   = 1'b1;
      mem_addr = ptr_ff;
    end else if (print) begin
      mem_we = 1'b1;
    end
  end

  tcci_refresh_mem u_mem (
    .clk      (CLK),
    .ce       (CE),
    .we       (mem_we),
    .re       (mem_re),
    .addr     (mem_addr),
    .wdata    (mem_wdata),
    .rdata_ff (mem_rdata)
  );

  assign word_end = (mem_rdata[7:0] == tcci_pkg::END_CHAR) &&
                    (mem_rdata[15:8] == tcci_pkg::END_STATUS);
  assign tx_fire  = TX_VALID && TX_READY;
  assign TX_VALID = (state_ff == tcci_pkg::TCCI_TX_CHAR && !word_end) ||
                    (state_ff == tcci_pkg::TCCI_TX_STAT) ||
                    (state_ff == tcci_pkg::TCCI_TX_CR);
  assign TX_DATA  = (state_ff == tcci_pkg::TCCI_TX_CHAR) ?
                    mem_rdata[7:0] : tx_data_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      tcci_pkg::TCCI_IDLE: begin
        if (ctl && code == tcci_pkg::CODE_ERASE_PAGE) begin
          nxt_state = tcci_pkg::TCCI_ERASE;
        end else if (ctl && code == tcci_pkg::CODE_TRANSMIT) begin
          nxt_state = tcci_pkg::TCCI_TX_READ;
        end
      end
      tcci_pkg::TCCI_ERASE: begin
        if (ptr_ff == last_addr) begin
          nxt_state = tcci_pkg::TCCI_IDLE;
        end
      end
      tcci_pkg::TCCI_TX_READ: begin
        nxt_state = tcci_pkg::TCCI_TX_CHAR;
      end
      tcci_pkg::TCCI_TX_CHAR: begin
        if (word_end) begin
          nxt_state = tcci_pkg::TCCI_TX_CR;
        end else if (tx_fire) begin
          nxt_state = tcci_pkg::TCCI_TX_STAT;
        end
      end
      tcci_pkg::TCCI_TX_STAT: begin
        if (tx_fire) begin
          nxt_state = (ptr_ff == last_addr) ? tcci_pkg::TCCI_TX_CR :
                      tcci_pkg::TCCI_TX_READ;
        end
      end
      tcci_pkg::TCCI_TX_CR: begin
        if (tx_fire) begin
          nxt_state = tcci_pkg::TCCI_IDLE;
        end
      end
      default: begin
        nxt_state = tcci_pkg::TCCI_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_ff <= tcci_pkg::TCCI_IDLE;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // Walk pointer for erase and transmit
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ptr_ff <= 12'h000;
    end else if (CE) begin
      if (state_ff == tcci_pkg::TCCI_IDLE) begin
        ptr_ff <= (code == tcci_pkg::CODE_TRANSMIT) ? cur_addr : 12'h000;
      end else if (state_ff == tcci_pkg::TCCI_ERASE) begin
        ptr_ff <= ptr_ff + 12'h001;
      end else if (state_ff == tcci_pkg::TCCI_TX_STAT && tx_fire) begin
        ptr_ff <= ptr_ff + 12'h001;
      end
    end
  end

  // Data byte is loaded one step ahead so TX_DATA comes from a flop;
  // embedded carriage returns in memory pass as plain data
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tx_data_ff <= 8'h00;
    end else if (CE) begin
      if (state_ff == tcci_pkg::TCCI_TX_READ) begin
        tx_data_ff <= 8'h00;
      end
      if (nxt_state == tcci_pkg::TCCI_TX_STAT) begin
        tx_data_ff <= mem_rdata[15:8];
      end else if (nxt_state == tcci_pkg::TCCI_TX_CR) begin
        tx_data_ff <= ctrl_ff[tcci_pkg::CTRL_CR_HIGH_BIT] ?
                      tcci_pkg::CR_HIGH : tcci_pkg::CR_PLAIN;
      end
    end
  end

  // Character byte is driven from the memory's read register in
  // TX_CHAR, which saves a second byte register on the send path

  // Visible cursor
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cur_x_ff <= 7'h00;
      cur_y_ff <= 6'h00;
    end else if (CE && ctl) begin
      if (code == tcci_pkg::CODE_ERASE_PAGE) begin
        cur_x_ff <= 7'h00;
        cur_y_ff <= 6'h00;
      end else if (code == tcci_pkg::CODE_CR) begin
        cur_x_ff <= 7'h00;
      end else if (code == tcci_pkg::CODE_RIGHT || print) begin
        if (cur_x_ff == tcci_pkg::LAST_COL) begin
          cur_x_ff <= 7'h00;
          cur_y_ff <= (cur_y_ff == last_line) ? 6'h00 : cur_y_ff + 6'h01;
        end else begin
          cur_x_ff <= cur_x_ff + 7'h01;
        end
      end else if (code == tcci_pkg::CODE_LEFT) begin
        if (cur_x_ff == 7'h00) begin
          cur_x_ff <= tcci_pkg::LAST_COL;
          cur_y_ff <= (cur_y_ff == 6'h00) ? last_line : cur_y_ff - 6'h01;
        end else begin
          cur_x_ff <= cur_x_ff - 7'h01;
        end
      end else if (code == tcci_pkg::CODE_UP) begin
        cur_y_ff <= (cur_y_ff == 6'h00) ? last_line :
                    cur_y_ff - 6'h01;
      end
    end
  end

  // Blind cursor is only homed here; no logic in the design reads or addresses it
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      blind_x_ff <= 7'h00;
      blind_y_ff <= 6'h00;
    end else if (CE && ctl && code == tcci_pkg::CODE_ERASE_PAGE) begin
      blind_x_ff <= 7'h00;
      blind_y_ff <= 6'h00;
    end
  end

  // Composite status, layout fg 0-2, bg 3-5, blink 6, plot 7
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      status_ff <= tcci_pkg::STATUS_RESET;
    end else if (CE && ctl) begin
      if (code >= tcci_pkg::CODE_COLOR_LO &&
          code <= tcci_pkg::CODE_COLOR_HI) begin
        if (rev_ff) begin
          status_ff[tcci_pkg::BG_LSB +: 3] <= code[2:0];
        end else begin
          status_ff[tcci_pkg::FG_LSB +: 3] <= code[2:0];
        end
      end else if (code == tcci_pkg::CODE_BLINK_OFF) begin
        status_ff[tcci_pkg::BLINK_BIT] <= 1'b0;
      end else if (code == tcci_pkg::CODE_BLINK_ON) begin
        status_ff[tcci_pkg::BLINK_BIT] <= 1'b1;
      end
    end
  end

  // Reverse-field flag and forced high character bit
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rev_ff <= 1'b0;
      hi_ff  <= 1'b0;
    end else if (CE && ctl) begin
      if (code == tcci_pkg::CODE_FLAG_OFF) begin
        rev_ff <= 1'b0;
      end else if (code == tcci_pkg::CODE_FLAG_ON) begin
        rev_ff <= 1'b1;
      end else if (code == tcci_pkg::CODE_HI_ON) begin
        hi_ff <= 1'b1;
      end else if (code == tcci_pkg::CODE_BLINK_OFF) begin
        hi_ff <= 1'b0;
      end
    end
  end

  // Software control: carriage return choice and screen height
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_ff <= tcci_pkg::CTRL_RESET;
    end else if (CE && REG_WR && REG_ADDR == tcci_pkg::REG_CTRL) begin
      ctrl_ff <= REG_WDATA[1:0];
    end
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_ff <= 32'h0000_0000;
    end else if (CE) begin
      rdata_ff <= 32'h0000_0000;
      if (REG_RD) begin
        unique case (REG_ADDR)
          tcci_pkg::REG_CTRL: begin
            rdata_ff[1:0] <= ctrl_ff;
          end
          tcci_pkg::REG_CURSOR: begin
            rdata_ff[6:0] <= cur_x_ff;
            rdata_ff[tcci_pkg::CURSOR_Y_LSB +: 6] <= cur_y_ff;
          end
          tcci_pkg::REG_STATUS: begin
            rdata_ff[7:0] <= status_ff;
            rdata_ff[tcci_pkg::STAT_REV_BIT] <= rev_ff;
            rdata_ff[tcci_pkg::STAT_HI_BIT] <= hi_ff;
            rdata_ff[tcci_pkg::STAT_BUSY_BIT] <=
              (state_ff != tcci_pkg::TCCI_IDLE);
          end
          tcci_pkg::REG_KBD_MODE: begin
            rdata_ff[4:0] <= kbd_mode;
            rdata_ff[tcci_pkg::MODE_COMM_LSB +: 2] <= kbd_comm;
            rdata_ff[tcci_pkg::MODE_ESC_BIT] <= kbd_esc;
          end
          tcci_pkg::REG_SER_MODE: begin
            rdata_ff[4:0] <= ser_mode;
            rdata_ff[tcci_pkg::MODE_COMM_LSB +: 2] <= ser_comm;
            rdata_ff[tcci_pkg::MODE_ESC_BIT] <= ser_esc;
          end
          default: begin
            rdata_ff <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign REG_RDATA = rdata_ff;
endmodule

// ### dv/tcci_top_asserts.sv
/*
  Port checker for the interpreter top, bound from the bench.
  Assumes no keyboard escape function byte equals code 12 or 24.
*/
`timescale 1ns/1ps
module tcci_chk (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       CE,
  input wire logic       KBD_VALID,
  input wire logic [7:0] KBD_DATA,
  input wire logic       KBD_READY,
  input wire logic       SER_READY,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_READY
);
  wire k_take = CE && KBD_VALID && KBD_READY;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_ser_prio: assert property (
    SER_READY |-> KBD_READY && !KBD_VALID)
    else $error("serial accepted beside keyboard");
  a_tx_busy: assert property (
    TX_VALID |-> !KBD_READY && !SER_READY)
    else $error("input taken while transmitting");
  a_tx_start: assert property (
    k_take && KBD_DATA == 8'h18 |=> !TX_VALID ##1 TX_VALID)
    else $error("transmit did not start in two cycles");
  a_tx_hold: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("tx byte dropped during stall");
  a_ce_freeze: assert property (
    !CE && TX_VALID |=> TX_VALID && $stable(TX_DATA))
    else $error("tx moved with clock enable low");
  a_erase_busy: assert property (
    k_take && KBD_DATA == 8'h0c |=> !KBD_READY [*8])
    else $error("erase did not hold the inputs off");
  a_print_idle: assert property (
    k_take && KBD_DATA >= 8'h20 |=> KBD_READY)
    else $error("printable byte stalled the input");
  a_move_idle: assert property (
    k_take && KBD_DATA inside {8'h0d, 8'h19, 8'h1a, 8'h1c} |=> KBD_READY)
    else $error("cursor move stalled the input");
endmodule

// ### dv/tcci_host_model.sv
/*
  Host on the far side: sends serial bytes and takes TX bytes with
  random stalls. Assumes the bench calls send right after a clock edge.
*/
`timescale 1ns/1ps
module tcci_host_model (
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       ser_ready,
  output logic            ser_valid,
  output logic [7:0]      ser_data
);
  logic [7:0] rx_q[$];
  int         hseed = 32'h51;
  initial begin
    tx_ready = 1'b0;
    ser_valid = 1'b0;
    ser_data = 8'h00;
  end
  // Sampled mid-cycle so the comb valid has settled after the edge
  always @(negedge clk) begin
    if (tx_valid && tx_ready && ce)
      rx_q.push_back(tx_data);
  end
  always @(posedge clk) begin
    tx_ready <= ($random(hseed) % 3) != 0;
  end
  task automatic send(input logic [7:0] b);
    ser_valid <= 1'b1;
    ser_data <= b;
    do @(negedge clk); while (ser_ready !== 1'b1);
    @(posedge clk);
    ser_valid <= 1'b0;
    // A released line must not keep showing the taken byte
    ser_data <= ~b;
    @(posedge clk);
  endtask
endmodule

// ### dv/tb_terminal_control_code_interpreter.sv
/*
  Self-checking bench for the interpreter top.
  Assumes the host model on the serial side and the bound checker.
*/
`timescale 1ns/1ps
module tb_terminal_control_code_interpreter;
  logic        CLK, RSTN, CE, KBD_VALID, REG_WR, REG_RD, TX_VALID;
  logic        KBD_READY, SER_READY, SER_VALID, TX_READY;
  logic [7:0]  KBD_DATA, SER_DATA, TX_DATA, REG_ADDR, c, st;
  logic [31:0] REG_WDATA, REG_RDATA, d;
  logic [7:0]  q[$];
  logic [4:0]  m;
  logic [1:0]  cm;
  int          num_errors, check_count, cyc, n, seed = 32'h2a7c;
  tcci_top dut (.CLK(CLK), .RSTN(RSTN), .CE(CE), .KBD_VALID(KBD_VALID),
    .KBD_DATA(KBD_DATA), .KBD_READY(KBD_READY), .SER_VALID(SER_VALID),
    .SER_DATA(SER_DATA), .SER_READY(SER_READY), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_READY(TX_READY), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA));
  tcci_host_model host (.clk(CLK), .ce(CE), .tx_valid(TX_VALID),
    .tx_data(TX_DATA), .tx_ready(TX_READY), .ser_ready(SER_READY),
    .ser_valid(SER_VALID), .ser_data(SER_DATA));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  // Every task starts just after a rising edge and ends on one
  task automatic kb(input logic [7:0] b);
    KBD_VALID <= 1'b1;
    KBD_DATA <= b;
    do @(negedge CLK); while (KBD_READY !== 1'b1);
    @(posedge CLK);
    KBD_VALID <= 1'b0;
    KBD_DATA <= ~b;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    d = REG_RDATA;
    @(posedge CLK);
  endtask
  task automatic idle();
    do @(negedge CLK); while (KBD_READY !== 1'b1);
    @(posedge CLK);
  endtask
  task automatic cst(input logic rev, hi);
    rd(tcci_pkg::REG_STATUS);
    chk("status", {22'h0, hi, rev, st}, d & 32'h3ff);
  endtask
  task automatic cur(input logic [6:0] x, input logic [5:0] y);
    rd(tcci_pkg::REG_CURSOR);
    chk("cursor", {18'h0, y, 1'b0, x}, d);
  endtask
  // Clock enable drops at random while the host also stalls
  task automatic txrun(input logic [7:0] cr);
    q.push_back(cr);
    kb(tcci_pkg::CODE_TRANSMIT);
    do @(negedge CLK); while (TX_VALID !== 1'b1);
    while (KBD_READY !== 1'b1) begin
      @(posedge CLK);
      CE <= ($random(seed) & 3) != 0;
      @(negedge CLK);
    end
    @(posedge CLK);
    CE <= 1'b1;
    chk("tx count", q.size(), host.rx_q.size());
    foreach (q[i]) chk("tx byte", q[i], host.rx_q[i]);
    q.delete();
    host.rx_q.delete();
    $display("test transmit done");
  endtask
  initial begin
    {CE, RSTN, KBD_VALID, REG_WR, REG_RD} = 5'b10000;
    {KBD_DATA, REG_ADDR, REG_WDATA} = '0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    st = 8'h07;
    cst(1'b0, 1'b0);
    cur(7'h0, 6'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    n = 1 + ($random(seed) & 7);
    for (int i = 0; i < n; i++) kb(8'h20 + ($random(seed) & 8'h3f));
    cur(7'(n), 6'h0);
    kb(8'h19);
    kb(8'h0c);
    idle();
    cur(7'h0, 6'h0);
    kb(8'h19);
    cur(7'h1, 6'h0);
    kb(8'h1a);
    cur(7'h0, 6'h0);
    kb(8'h1c);
    kb(8'h19);
    kb(8'h0d);
    cur(7'h0, 6'h18);
    wr(tcci_pkg::REG_CTRL, 32'h2);
    kb(8'h0c);
    idle();
    kb(8'h1c);
    cur(7'h0, 6'h2f);
    wr(tcci_pkg::REG_CTRL, 32'h0);
    $display("test cursor done");
    for (int i = 16; i < 24; i++) begin
      kb(8'(i));
      st = 8'(i - 16);
      cst(1'b0, 1'b0);
    end
    kb(8'h1e);
    for (int i = 16; i < 24; i++) begin
      kb(8'(i));
      st = {2'b0, 3'(i - 16), 3'b111};
      cst(1'b1, 1'b0);
    end
    kb(8'h1d);
    kb(8'h1f);
    kb(8'h0e);
    st = 8'h7f;
    cst(1'b0, 1'b1);
    kb(8'h0f);
    st = 8'h3f;
    cst(1'b0, 1'b0);
    $display("test status done");
    m = 5'h0;
    cm = 2'h0;
    for (int f = 0; f < 32; f++) begin
      host.send(tcci_pkg::CODE_ESCAPE);
      host.send({3'($random(seed)), 5'(f)});
      cm = f == 6 ? 2'h2 : f == 8 ? 2'h1 : f == 12 ? 2'h0 : cm;
      if (!(f inside {4, 6, 7, 8, 9, 12, 13, 14, 27}))
        m = 5'(f);
      rd(tcci_pkg::REG_SER_MODE);
      chk("serial mode", {22'h0, cm, 3'h0, m}, d);
    end
    host.send(tcci_pkg::CODE_ESCAPE);
    host.send(8'h40);
    rd(tcci_pkg::REG_KBD_MODE);
    chk("keyboard mode", 32'h0, d);
    kb(tcci_pkg::CODE_ESCAPE);
    kb(8'h06);
    kb(8'h41);
    cur(7'h0, 6'h2f);
    rd(tcci_pkg::REG_KBD_MODE);
    chk("keyboard mode", 32'h200, d);
    kb(tcci_pkg::CODE_ESCAPE);
    kb(8'h4c);
    rd(tcci_pkg::REG_KBD_MODE);
    chk("keyboard mode", 32'h0, d);
    $display("test escape done");
    wr(tcci_pkg::REG_CTRL, 32'h1);
    kb(8'h0c);
    idle();
    for (int i = 0; i < n; i++) begin
      c = 8'h20 + ($random(seed) & 8'h3f);
      kb(c);
      q.push_back(c);
      q.push_back(st);
    end
    c = 8'($random(seed) & 8'h1f);
    kb(8'h1e);
    kb(8'h60 | c);
    q.push_back(c);
    q.push_back(st);
    kb(8'h1d);
    kb(8'h60 | c);
    q.push_back(8'h60 | c);
    q.push_back(st);
    kb(8'h10);
    kb(8'h1e);
    kb(8'h10);
    kb(8'h1d);
    kb(8'h0e);
    kb(8'hff);
    kb(8'h0f);
    kb(8'h0d);
    txrun(tcci_pkg::CR_HIGH);
    wr(tcci_pkg::REG_CTRL, 32'h0);
    kb(8'h17);
    kb(8'h0c);
    idle();
    kb(8'h1c);
    for (int i = 0; i < 80; i++) begin
      q.push_back(tcci_pkg::SPACE_CHAR);
      q.push_back(8'h07);
    end
    txrun(tcci_pkg::CR_PLAIN);
    test_done();
  end
endmodule
bind tcci_top tcci_chk chk (.CLK(CLK), .RSTN(RSTN), .CE(CE),
  .KBD_VALID(KBD_VALID), .KBD_DATA(KBD_DATA), .KBD_READY(KBD_READY),
  .SER_READY(SER_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_READY(TX_READY));
